/* design/ect_capture_timer.sv */
`timescale 1ns/1ps
// Operation
// [RULE_01] Each mode's interrupt condition sets the capture flag.
// [RULE_02] Interrupt line high while flag and enable both set.
// [RULE_03] Enable bit write never changes the flag.
// [RULE_04] Stop in power-down; standby runs only with run_in_standby.
// [RULE_05] Run_in_standby bit 6 ignored when clock select is companion.
// [RULE_06] Restart_with_companion bit 4 restarts counter with companion.
// [RULE_07] Clock select: peripheral, half peripheral, companion, reserved.
// [RULE_08] Enable bit 0 of control_first switches timer on.
// [RULE_09] Single-shot output high on start, or at event if output_enable_a.
// [RULE_10] Output initial level bit 5 sets the pin's idle level; single-shot and PWM modes ignore it.
// [RULE_11] Compare output enable bit 4 zero forces output low.
// [RULE_12] Three-bit mode field selects one of eight modes.
// [RULE_13] Filter bit 6 turns on event noise cancellation.
// [RULE_14] Periodic and PWM modes ignore event edges.
// [RULE_15] Time-out mode: one edge starts, the other stops counting.
// [RULE_16] Capture mode: selected edge loads capture and flags.
// [RULE_17] Frequency mode: selected edge captures, clears, restarts, flags.
// [RULE_18] Pulse mode: one edge restarts, the other captures and flags.
// [RULE_19] Combined mode edge 0: rise restart, fall capture, rise stop.
// [RULE_20] Combined mode edge 1: same sequence with polarities swapped.
// [RULE_21] Single-shot starts on rising edge, or both edges if edge set.
// [RULE_22] Each flag set also emits a one-cycle event strobe.
// [RULE_23] Filter passes a change after four equal clock samples.
// [RULE_24] Flag clears on write one, or capture read in capture modes.
// [RULE_25] Run state bit reads one while the counter counts.
module ect_capture_timer
	import ect_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic event_in,
	input wire logic companion_tick,
	input wire logic companion_restart,
	input wire logic sleep_standby,
	input wire logic sleep_powerdown,
	input wire logic debug_halt,
	output logic irq,
	output logic event_strobe,
	output logic wave_out
);
	logic [7:0] control_first;
	logic [7:0] control_second;
	logic [7:0] event_input_control;
	logic [7:0] interrupt_enable;
	logic [7:0] debug_halt_control;
	logic [7:0] wide_access_buffer;
	logic [15:0] counter_value;
	logic [15:0] compare_capture_value;
	logic capture_flag;
	logic running;
	logic enable_q;
	logic ss_pending;
	ect_fp_e fp_state;

	logic [15:0] next_cnt;
	logic next_run;
	logic next_flag;
	logic next_wave;
	ect_fp_e next_fp;
	logic capture_flag_set;
	logic cap_load;
	logic ss_trig;
	logic flag_clr;
	logic halted;
	logic ev_ok;
	logic ev_pos;
	logic ev_neg;
	logic access;
	logic [31:0] rd_mux;
	logic rd_hit;

	wire logic timer_en = control_first[CF_ENABLE];
	wire logic [1:0] clk_sel = control_first[CF_CLOCK_SOURCE_SELECT_LO +: 2];
	wire logic [2:0] mode = control_second[CS_MODE_LO +: 3];
	wire logic edge_sel = event_input_control[EV_EDGE];

	ect_core_if core_bus();

	ect_noise_filter u_filter (
		.pclk(pclk),
		.presetn(presetn),
		.bus(core_bus.filt)
	);

	ect_tick_gen u_tick (
		.pclk(pclk),
		.presetn(presetn),
		.bus(core_bus.tick_src)
	);

	assign core_bus.ev_level = event_in;
	assign core_bus.filter_en = event_input_control[EV_FILTER]; // [RULE_13]
	assign core_bus.clk_sel = clk_sel;
	assign core_bus.comp_tick = companion_tick;
	assign core_bus.run_en = timer_en & ~halted; // [RULE_08]

	function automatic logic at(input logic [7:0] idx);
		at = paddr == {2'b00, idx, 2'b00};
	endfunction

	assign access = psel & penable & pready;

	function automatic logic wr(input logic [7:0] idx);
		wr = access & pwrite & at(idx);
	endfunction

	// Companion clock drives this timer in standby regardless of the bit
	always_comb begin
		halted = sleep_powerdown; // [RULE_04]
		if (sleep_standby && !control_first[CF_RUN_STANDBY]
			&& clk_sel != CLK_COMPANION) begin // [RULE_05]
			halted = 1'b1;
		end
		if (debug_halt && !debug_halt_control[BIT0]) begin
			halted = 1'b1;
		end
	end

	assign ev_ok = timer_en & ~halted & event_input_control[EV_INPUT_EN];
	assign ev_pos = edge_sel ? core_bus.fall : core_bus.rise;
	assign ev_neg = edge_sel ? core_bus.rise : core_bus.fall;

	assign flag_clr = wr(IDX_INT_FLAG) & pwdata[BIT0]
		| access & ~pwrite & at(IDX_COMPARE)
		& (mode >= MODE_CAPTURE_FLAG_EVT) & (mode <= MODE_FREQ_PULSE); // [RULE_24]

	always_comb begin
		next_cnt = counter_value;
		next_run = running;
		next_fp = fp_state;
		capture_flag_set = 1'b0;
		cap_load = 1'b0;
		ss_trig = 1'b0;
		if (!timer_en) begin
			next_run = 1'b0;
			next_fp = FP_IDLE;
		end else begin
			if (!enable_q) begin
				next_run = mode != MODE_TIMEOUT && mode != MODE_FREQ_PULSE;
			end
			if (core_bus.tick && running) begin
				case (mode)
					MODE_PWM8: begin
						if (counter_value[7:0] == compare_capture_value[7:0]) begin
							next_cnt = WORD_RST;
							capture_flag_set = 1'b1; // [RULE_01]
						end else begin
							next_cnt = counter_value + WORD_ONE;
						end
					end
					MODE_PERIODIC, MODE_TIMEOUT: begin
						if (counter_value == compare_capture_value) begin
							next_cnt = WORD_RST;
							capture_flag_set = 1'b1; // [RULE_01]
						end else begin
							next_cnt = counter_value + WORD_ONE;
						end
					end
					MODE_SINGLE: begin
						if (counter_value == compare_capture_value) begin
							next_run = 1'b0;
							capture_flag_set = 1'b1; // [RULE_01]
						end else begin
							next_cnt = counter_value + WORD_ONE;
						end
					end
					default: next_cnt = counter_value + WORD_ONE;
				endcase
			end
			if (ev_ok) begin
				case (mode) // [RULE_12]
					MODE_TIMEOUT: begin
						if (ev_pos) begin
							next_run = 1'b1; // [RULE_15]
						end
						if (ev_neg) begin
							next_run = 1'b0; // [RULE_15]
						end
					end
					MODE_CAPTURE_FLAG_EVT: begin
						if (ev_pos) begin
							cap_load = 1'b1; // [RULE_16]
							capture_flag_set = 1'b1;
						end
					end
					MODE_FREQ: begin
						if (ev_pos) begin
							cap_load = 1'b1; // [RULE_17]
							capture_flag_set = 1'b1;
							next_cnt = WORD_RST;
							next_run = 1'b1;
						end
					end
					MODE_PULSE: begin
						if (ev_pos) begin
							next_cnt = WORD_RST; // [RULE_18]
							next_run = 1'b1;
						end
						if (ev_neg) begin
							cap_load = 1'b1; // [RULE_18]
							capture_flag_set = 1'b1;
						end
					end
					MODE_FREQ_PULSE: begin
						case (fp_state) // [RULE_19] [RULE_20]
							FP_IDLE: begin
								if (ev_pos) begin
									next_cnt = WORD_RST;
									next_run = 1'b1;
									next_fp = FP_HIGH;
								end
							end
							FP_HIGH: begin
								if (ev_neg) begin
									cap_load = 1'b1;
									next_fp = FP_LOW;
								end
							end
							FP_LOW: begin
								if (ev_pos) begin
									next_run = 1'b0;
									capture_flag_set = 1'b1;
									next_fp = FP_DONE;
								end
							end
							default: ;
						endcase
					end
					MODE_SINGLE: begin
						// Events during a running shot are dropped
						if (!running && !ss_pending
							&& (core_bus.rise || edge_sel && core_bus.fall)) begin
							ss_trig = 1'b1; // [RULE_21]
						end
					end
					default: ; // [RULE_14]
				endcase
			end
			if (ss_pending) begin
				next_cnt = WORD_RST;
				next_run = 1'b1;
			end
			if (fp_state == FP_DONE && flag_clr) begin
				next_fp = FP_IDLE;
			end
			if (control_first[CF_RESTART_SYNC] && companion_restart
				&& !halted) begin
				next_cnt = WORD_RST; // [RULE_06]
			end
		end
	end

	// Set beats a clear landing in the same cycle
	assign next_flag = capture_flag_set | (capture_flag & ~flag_clr); // [RULE_24]

	always_comb begin
		if (!control_second[CS_OUT_EN]) begin
			next_wave = 1'b0; // [RULE_11]
		end else begin
			case (mode)
				MODE_SINGLE: begin
					next_wave = next_run; // [RULE_09]
					if (control_second[CS_OUTPUT_ENABLE_A] && (ss_trig || ss_pending)) begin
						next_wave = 1'b1; // [RULE_09]
					end
				end
				MODE_PWM8: begin
					next_wave = compare_capture_value[7:0] != BYTE_RST
						&& next_cnt[7:0] < compare_capture_value[15:8];
				end
				default: next_wave = control_second[CS_INIT_LVL]; // [RULE_10]
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			control_first <= BYTE_RST;
			control_second <= BYTE_RST;
			event_input_control <= BYTE_RST;
			interrupt_enable <= BYTE_RST;
			debug_halt_control <= BYTE_RST;
			wide_access_buffer <= BYTE_RST;
		end else begin
			if (wr(IDX_CTRL_FIRST)) begin
				control_first <= pwdata[7:0] & CF_MASK;
			end
			if (wr(IDX_CTRL_SECOND)) begin
				control_second <= pwdata[7:0] & CS_MASK;
			end
			if (wr(IDX_EVENT_CTRL)) begin
				event_input_control <= pwdata[7:0] & EV_MASK;
			end
			if (wr(IDX_INT_ENABLE)) begin
				interrupt_enable <= pwdata[7:0] & BIT0_MASK; // [RULE_03]
			end
			if (wr(IDX_DEBUG_CTRL)) begin
				debug_halt_control <= pwdata[7:0] & BIT0_MASK;
			end
			if (wr(IDX_WIDE_BUF)) begin
				wide_access_buffer <= pwdata[7:0];
			end
		end
	end

	// Software writes to the counter win over counting
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			counter_value <= WORD_RST;
		end else if (wr(IDX_COUNTER)) begin
			counter_value <= pwdata[15:0];
		end else begin
			counter_value <= next_cnt;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			compare_capture_value <= WORD_RST;
		end else if (wr(IDX_COMPARE)) begin
			compare_capture_value <= pwdata[15:0];
		end else if (cap_load) begin
			compare_capture_value <= counter_value;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			running <= 1'b0;
			enable_q <= 1'b0;
			ss_pending <= 1'b0;
			fp_state <= FP_IDLE;
		end else begin
			running <= next_run; // [RULE_25]
			enable_q <= timer_en;
			ss_pending <= ss_trig;
			fp_state <= next_fp;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			capture_flag <= 1'b0;
			irq <= 1'b0;
			event_strobe <= 1'b0;
			wave_out <= 1'b0;
		end else begin
			capture_flag <= next_flag; // [RULE_01]
			irq <= next_flag & interrupt_enable[BIT0]; // [RULE_02]
			event_strobe <= capture_flag_set; // [RULE_22]
			wave_out <= next_wave;
		end
	end

	always_comb begin
		rd_hit = 1'b1;
		rd_mux = '0;
		case (paddr)
			{2'b00, IDX_CTRL_FIRST, 2'b00}: rd_mux[7:0] = control_first;
			{2'b00, IDX_CTRL_SECOND, 2'b00}: rd_mux[7:0] = control_second;
			{2'b00, IDX_EVENT_CTRL, 2'b00}: rd_mux[7:0] = event_input_control;
			{2'b00, IDX_INT_ENABLE, 2'b00}: rd_mux[7:0] = interrupt_enable;
			{2'b00, IDX_INT_FLAG, 2'b00}: rd_mux[BIT0] = capture_flag;
			{2'b00, IDX_RUN_STATE, 2'b00}: rd_mux[BIT0] = running; // [RULE_25]
			{2'b00, IDX_DEBUG_CTRL, 2'b00}: rd_mux[7:0] = debug_halt_control;
			{2'b00, IDX_WIDE_BUF, 2'b00}: rd_mux[7:0] = wide_access_buffer;
			{2'b00, IDX_COUNTER, 2'b00}: rd_mux[15:0] = counter_value;
			{2'b00, IDX_COMPARE, 2'b00}: rd_mux[15:0] = compare_capture_value;
			default: rd_hit = 1'b0;
		endcase
	end

	// One wait-free access cycle; answer registered from the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
		end else begin
			pready <= psel & ~penable & ~pready;
			pslverr <= psel & ~penable & ~pready & ~rd_hit;
			if (psel && !penable && (!pwrite || !rd_hit)) begin
				prdata <= rd_mux;
			end
		end
	end
endmodule

/* design/ect_noise_filter.sv */
`timescale 1ns/1ps
module ect_noise_filter
	import ect_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	ect_core_if.filt bus
);
	logic [FILTER_LEN-1:0] hist;
	logic level;
	logic level_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hist <= '0;
		end else begin
			hist <= {hist[FILTER_LEN-2:0], bus.ev_level};
		end
	end

	// With the filter on, level only moves once the sample history agrees
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			level <= 1'b0;
		end else if (!bus.filter_en) begin
			level <= bus.ev_level;
		end else if (hist == '1 || hist == '0) begin // [RULE_23]
			level <= hist[FILTER_LEN-1];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			level_q <= 1'b0;
		end else begin
			level_q <= level;
		end
	end

	assign bus.rise = level & ~level_q;
	assign bus.fall = ~level & level_q;
endmodule

/* design/ect_tick_gen.sv */
`timescale 1ns/1ps
module ect_tick_gen
	import ect_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	ect_core_if.tick_src bus
);
	logic half;

	// Divider only advances while the timer runs, keeps phase stable
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			half <= 1'b0;
		end else if (bus.run_en) begin
			half <= ~half;
		end
	end

	always_comb begin
		case (bus.clk_sel) // [RULE_07]
			PERIPHERAL_CLOCK: bus.tick = bus.run_en;
			PERIPHERAL_CLOCK_DIV2: bus.tick = bus.run_en & half;
			CLK_COMPANION: bus.tick = bus.run_en & bus.comp_tick;
			default: bus.tick = 1'b0;
		endcase
	end
endmodule

/* dv/ect_capture_timer_asserts.sv */
`timescale 1ns/1ps
module ect_capture_timer_asserts
	import ect_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic sleep_powerdown,
	input wire logic irq,
	input wire logic event_strobe
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_access;
		s_setup ##1 (psel && penable);
	endsequence
	AST_READY_IN_ACCESS: assert property (s_access |-> pready)
		else $error("pready missing in first access cycle");
	AST_READY_ONE_CYCLE: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	AST_READY_ONLY_ACCESS: assert property (pready |-> psel && penable)
		else $error("pready outside an access cycle");
	AST_ERR_UNALIGNED: assert property (
		psel && penable && pready && (paddr[1:0] != 2'h0)
		|-> pslverr && (prdata == 32'h0))
		else $error("misaligned access not refused");
	AST_STROBE_PULSE: assert property (
		event_strobe |=> !event_strobe)
		else $error("event strobe longer than one cycle");
	AST_IRQ_HOLD: assert property (
		irq && !(psel && penable) && !($past(psel) && $past(penable))
		|=> irq)
		else $error("irq dropped without a register access");
	AST_IRQ_CAUSE: assert property (
		$rose(irq) |-> event_strobe
		|| $past(psel, 2) && $past(penable, 2) && $past(pwrite, 2))
		else $error("irq rose without flag set or enable write");
	AST_POWERDOWN: assert property (
		sleep_powerdown [*4] |-> !event_strobe)
		else $error("timer active in power-down");
endmodule

/* dv/ect_capture_timer_tb.sv */
`timescale 1ns/1ps
module ect_capture_timer_tb
	import ect_pkg::*;
;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [ADDR_W-1:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd, cap_a;
	logic pready, pslverr, irq, event_strobe, wave_out, err;
	logic event_in, companion_tick, companion_restart;
	logic lvl_req = 1'b0, rst_req = 1'b0, debug_halt = 1'b0;
	logic sleep_standby = 1'b0, sleep_powerdown = 1'b0;
	int mismatches = 0;
	int n_tests = 0;
	int gap, l0, l1, l2, l3, l4;
	logic [7:0] idx_tab [8] = '{IDX_CTRL_FIRST, IDX_CTRL_SECOND,
		IDX_EVENT_CTRL, IDX_INT_ENABLE, IDX_INT_FLAG, IDX_RUN_STATE,
		IDX_COUNTER, IDX_COMPARE};
	// Clock select, standby, power-down rows; gap 0 means stopped
	logic [7:0] cf_tab [8] = '{8'h01, 8'h03, 8'h05, 8'h07,
		8'h01, 8'h41, 8'h05, 8'h41};
	logic [7:0] gp_tab [8] = '{8'h0A, 8'h14, 8'h1E, 8'h00,
		8'h00, 8'h0A, 8'h1E, 8'h00};
	logic [7:0] st_tab = 8'h70;
	logic [7:0] pd_tab = 8'h80;
	int per [3] = '{16, 31, 4};
	always #2 pclk = ~pclk;
	ect_capture_timer ect_capture_timer_inst (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.event_in(event_in), .companion_tick(companion_tick),
		.companion_restart(companion_restart),
		.sleep_standby(sleep_standby), .sleep_powerdown(sleep_powerdown),
		.debug_halt(debug_halt), .irq(irq), .event_strobe(event_strobe),
		.wave_out(wave_out));
	ect_evt_partner ect_evt_partner_inst (.pclk(pclk), .presetn(presetn),
		.lvl_req(lvl_req), .rst_req(rst_req), .event_in(event_in),
		.companion_tick(companion_tick),
		.companion_restart(companion_restart));
	function automatic logic [ADDR_W-1:0] ba(input logic [7:0] i);
		return {2'b00, i, 2'b00};
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic complete_run();
		$display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask
	task automatic guard(input int n, input int lim);
		if (n >= lim) begin
			mismatches++;
			complete_run();
		end
	endtask
	task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
		input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		guard(n, 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wr(input logic [7:0] i, input logic [15:0] d);
		apb(1'b1, ba(i), {16'h0000, d});
	endtask
	task automatic rdchk(input logic [7:0] i, input logic [15:0] e);
		apb(1'b0, ba(i), 32'h0);
		check(rd, {16'h0000, e});
	endtask
	task automatic measure(output int g);
		int n;
		g = 0;
		n = 0;
		while (event_strobe !== 1'b1 && n < 100) begin
			@(posedge pclk);
			n++;
		end
		if (n < 100) begin
			n = 0;
			do begin
				@(posedge pclk);
				n++;
			end while (event_strobe !== 1'b1 && n < 100);
			g = (n < 100) ? n : 0;
		end
	endtask
	task automatic irq_read();
		int n;
		n = 0;
		while (irq !== 1'b1 && n < 200) begin
			@(posedge pclk);
			n++;
		end
		guard(n, 200);
		apb(1'b0, ba(IDX_COMPARE), 32'h0);
	endtask
	task automatic ss_lat(input logic [15:0] cs, input logic [15:0] ev,
		output int lat);
		wr(IDX_CTRL_FIRST, 16'h0000);
		wr(IDX_CTRL_SECOND, cs);
		wr(IDX_EVENT_CTRL, ev);
		wr(IDX_COMPARE, 16'h0014);
		wr(IDX_COUNTER, 16'h0014);
		wr(IDX_CTRL_FIRST, 16'h0001);
		cyc(4);
		lvl_req <= ~lvl_req;
		lat = 0;
		while (wave_out !== 1'b1 && lat < 20) begin
			@(posedge pclk);
			lat++;
		end
		cyc(30);
	endtask
	initial begin
		cyc(16);
		presetn <= 1'b1;
		@(posedge pclk);
		foreach (idx_tab[k])
			rdchk(idx_tab[k], 16'h0000);
		apb(1'b0, ba(8'h02), 32'h0);
		check({31'h0, err}, 32'h1);
		apb(1'b0, 12'h002, 32'h0);
		check({31'h0, err}, 32'h1);
		for (int m = 0; m < 8; m++) begin
			wr(IDX_CTRL_SECOND, 16'(m));
			rdchk(IDX_CTRL_SECOND, 16'(m));
		end
		wr(IDX_EVENT_CTRL, 16'h00FF);
		rdchk(IDX_EVENT_CTRL, {8'h00, EV_MASK});
		wr(IDX_CTRL_FIRST, 16'h00FE);
		rdchk(IDX_CTRL_FIRST, 16'h0056);
		wr(IDX_COMPARE, 16'h0009);
		wr(IDX_CTRL_SECOND, {13'h0, MODE_PERIODIC});
		for (int k = 0; k < 8; k++) begin
			sleep_standby <= st_tab[k];
			sleep_powerdown <= pd_tab[k];
			wr(IDX_CTRL_FIRST, {8'h00, cf_tab[k]});
			measure(gap);
			check(32'(gap), {24'h0, gp_tab[k]});
			wr(IDX_CTRL_FIRST, 16'h0000);
		end
		sleep_standby <= 1'b0;
		sleep_powerdown <= 1'b0;
		// Restart with companion keeps the count far below the elapsed time
		wr(IDX_COMPARE, 16'hFFFF);
		wr(IDX_CTRL_FIRST, 16'h0011);
		cyc(40);
		rst_req <= 1'b1;
		@(posedge pclk);
		rst_req <= 1'b0;
		cyc(2);
		apb(1'b0, ba(IDX_COUNTER), 32'h0);
		check(32'(rd < 32'h10), 32'h1);
		rdchk(IDX_RUN_STATE, 16'h0001);
		wr(IDX_CTRL_FIRST, 16'h0000);
		wr(IDX_CTRL_SECOND, {13'h0, MODE_CAPTURE_FLAG_EVT});
		wr(IDX_INT_FLAG, 16'h0001);
		wr(IDX_EVENT_CTRL, 16'h0011);
		wr(IDX_INT_ENABLE, 16'h0001);
		wr(IDX_CTRL_FIRST, 16'h0001);
		lvl_req <= 1'b1;
		cyc(10);
		check(32'(irq), 32'h0);
		lvl_req <= 1'b0;
		cyc(10);
		check(32'(irq), 32'h1);
		wr(IDX_INT_ENABLE, 16'h0000);
		cyc(1);
		check(32'(irq), 32'h0);
		rdchk(IDX_INT_FLAG, 16'h0001);
		wr(IDX_INT_ENABLE, 16'h0001);
		apb(1'b0, ba(IDX_COMPARE), 32'h0);
		rdchk(IDX_INT_FLAG, 16'h0000);
		lvl_req <= 1'b1;
		cyc(4);
		lvl_req <= 1'b0;
		cyc(10);
		wr(IDX_INT_FLAG, 16'h0001);
		rdchk(IDX_INT_FLAG, 16'h0000);
		wr(IDX_CTRL_FIRST, 16'h0000);
		wr(IDX_CTRL_SECOND, {13'h0, MODE_FREQ});
		wr(IDX_EVENT_CTRL, 16'h0001);
		wr(IDX_CTRL_FIRST, 16'h0001);
		// Captures differ by exactly the change in edge spacing
		fork
			for (int k = 0; k < 3; k++) begin
				lvl_req <= 1'b1;
				cyc(4);
				lvl_req <= 1'b0;
				cyc(per[k]);
			end
			begin
				irq_read();
				irq_read();
				cap_a = rd;
				irq_read();
				check(rd - cap_a, 32'h0F);
			end
		join
		ss_lat(16'h0016, 16'h0001, l0);
		ss_lat(16'h0016, 16'h0001, l2);
		check(32'(l2), 32'h14);
		ss_lat(16'h0056, 16'h0001, l1);
		check(32'(l0 - l1), 32'h1);
		ss_lat(16'h0016, 16'h0011, l3);
		check(32'(l3 < 20), 32'h1);
		ss_lat(16'h0006, 16'h0001, l4);
		check(32'(l4), 32'h14);
		wr(IDX_CTRL_SECOND, 16'h0032);
		cyc(1);
		check(32'(wave_out), 32'h1);
		lvl_req <= 1'b0;
		wr(IDX_CTRL_FIRST, 16'h0000);
		wr(IDX_CTRL_SECOND, {13'h0, MODE_TIMEOUT});
		wr(IDX_EVENT_CTRL, 16'h0001);
		wr(IDX_COMPARE, 16'hFFFF);
		wr(IDX_CTRL_FIRST, 16'h0001);
		rdchk(IDX_RUN_STATE, 16'h0000);
		lvl_req <= 1'b1;
		cyc(6);
		rdchk(IDX_RUN_STATE, 16'h0001);
		lvl_req <= 1'b0;
		cyc(6);
		rdchk(IDX_RUN_STATE, 16'h0000);
		wr(IDX_EVENT_CTRL, 16'h0011);
		lvl_req <= 1'b1;
		cyc(6);
		lvl_req <= 1'b0;
		cyc(6);
		rdchk(IDX_RUN_STATE, 16'h0001);
		// Width difference cancels the fixed edge-detect latency
		wr(IDX_CTRL_SECOND, {13'h0, MODE_PULSE});
		wr(IDX_EVENT_CTRL, 16'h0001);
		wr(IDX_INT_FLAG, 16'h0001);
		lvl_req <= 1'b1;
		cyc(10);
		lvl_req <= 1'b0;
		cyc(8);
		check(32'(irq), 32'h1);
		apb(1'b0, ba(IDX_COMPARE), 32'h0);
		cap_a = rd;
		lvl_req <= 1'b1;
		cyc(17);
		lvl_req <= 1'b0;
		cyc(8);
		apb(1'b0, ba(IDX_COMPARE), 32'h0);
		check(rd - cap_a, 32'h07);
		wr(IDX_CTRL_SECOND, {13'h0, MODE_CAPTURE_FLAG_EVT});
		wr(IDX_EVENT_CTRL, 16'h0041);
		wr(IDX_INT_FLAG, 16'h0001);
		lvl_req <= 1'b1;
		cyc(3);
		lvl_req <= 1'b0;
		cyc(10);
		rdchk(IDX_INT_FLAG, 16'h0000);
		lvl_req <= 1'b1;
		cyc(5);
		lvl_req <= 1'b0;
		cyc(12);
		rdchk(IDX_INT_FLAG, 16'h0001);
		// Rise, fall, rise: stopped with edge 0, still running with edge 1
		wr(IDX_CTRL_SECOND, {13'h0, MODE_FREQ_PULSE});
		for (int j = 0; j < 2; j++) begin
			wr(IDX_EVENT_CTRL, j ? 16'h0011 : 16'h0001);
			wr(IDX_INT_FLAG, 16'h0001);
			lvl_req <= 1'b1;
			cyc(6);
			lvl_req <= 1'b0;
			cyc(6);
			lvl_req <= 1'b1;
			cyc(6);
			rdchk(IDX_RUN_STATE, 16'(j));
			lvl_req <= 1'b0;
			cyc(6);
			rdchk(IDX_RUN_STATE, 16'h0000);
			rdchk(IDX_INT_FLAG, 16'h0001);
		end
		wr(IDX_CTRL_SECOND, {13'h0, MODE_PERIODIC});
		wr(IDX_EVENT_CTRL, 16'h0001);
		wr(IDX_COMPARE, 16'hFFFF);
		wr(IDX_COUNTER, 16'h0000);
		wr(IDX_INT_FLAG, 16'h0001);
		lvl_req <= 1'b1;
		cyc(8);
		rdchk(IDX_INT_FLAG, 16'h0000);
		complete_run();
	end
endmodule
bind ect_capture_timer ect_capture_timer_asserts ect_capture_timer_asserts_inst (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .sleep_powerdown(sleep_powerdown), .irq(irq),
	.event_strobe(event_strobe));

/* dv/ect_evt_partner.sv */
`timescale 1ns/1ps
module ect_evt_partner (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic lvl_req,
	input wire logic rst_req,
	output logic event_in,
	output logic companion_tick,
	output logic companion_restart
);
	logic [1:0] div;
	// Companion runs free, one tick in three cycles
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div <= 2'h0;
			companion_tick <= 1'b0;
		end else begin
			div <= (div == 2'h2) ? 2'h0 : div + 2'h1;
			companion_tick <= (div == 2'h2);
		end
	end
	// Channel level is registered, so it stays synchronous to pclk
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			event_in <= 1'b0;
			companion_restart <= 1'b0;
		end else begin
			event_in <= lvl_req;
			companion_restart <= rst_req;
		end
	end
endmodule

/* shared/ect_core_if.sv */
`timescale 1ns/1ps
interface ect_core_if;
	logic ev_level;
	logic filter_en;
	logic rise;
	logic fall;
	logic [1:0] clk_sel;
	logic comp_tick;
	logic run_en;
	logic tick;
	modport filt(input ev_level, filter_en, output rise, fall);
	modport tick_src(input clk_sel, comp_tick, run_en, output tick);
	modport core(output ev_level, filter_en, clk_sel, comp_tick, run_en,
		input rise, fall, tick);
endinterface

/* shared/ect_pkg.sv */
package ect_pkg;
	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_CTRL_FIRST = 8'h00;
	localparam logic [7:0] IDX_CTRL_SECOND = 8'h01;
	localparam logic [7:0] IDX_EVENT_CTRL = 8'h04;
	localparam logic [7:0] IDX_INT_ENABLE = 8'h05;
	localparam logic [7:0] IDX_INT_FLAG = 8'h06;
	localparam logic [7:0] IDX_RUN_STATE = 8'h07;
	localparam logic [7:0] IDX_DEBUG_CTRL = 8'h08;
	localparam logic [7:0] IDX_WIDE_BUF = 8'h09;
	localparam logic [7:0] IDX_COUNTER = 8'h0A;
	localparam logic [7:0] IDX_COMPARE = 8'h0C;
	localparam int ADDR_W = 12;

	// control_first fields
	localparam int CF_ENABLE = 0;
	localparam int CF_CLOCK_SOURCE_SELECT_LO = 1;
	localparam int CF_RESTART_SYNC = 4;
	localparam int CF_RUN_STANDBY = 6;
	localparam logic [7:0] CF_MASK = 8'h57;
	// control_second fields
	localparam int CS_MODE_LO = 0;
	localparam int CS_OUT_EN = 4;
	localparam int CS_INIT_LVL = 5;
	localparam int CS_OUTPUT_ENABLE_A = 6;
	localparam logic [7:0] CS_MASK = 8'h77;
	// event_input_control fields
	localparam int EV_INPUT_EN = 0;
	localparam int EV_EDGE = 4;
	localparam int EV_FILTER = 6;
	localparam logic [7:0] EV_MASK = 8'h51;
	// Single-bit registers keep their bit in position 0
	localparam int BIT0 = 0;
	localparam logic [7:0] BIT0_MASK = 8'h01;

	localparam logic [7:0] BYTE_RST = 8'h00;
	localparam logic [15:0] WORD_RST = 16'h0000;
	localparam logic [15:0] WORD_ONE = 16'h0001;
	localparam logic [7:0] IRQ_VECTOR_OFFSET = 8'h00;
	localparam int FILTER_LEN = 4;

	localparam logic [1:0] PERIPHERAL_CLOCK = 2'h0;
	localparam logic [1:0] PERIPHERAL_CLOCK_DIV2 = 2'h1;
	localparam logic [1:0] CLK_COMPANION = 2'h2;

	localparam logic [2:0] MODE_PERIODIC = 3'h0;
	localparam logic [2:0] MODE_TIMEOUT = 3'h1;
	localparam logic [2:0] MODE_CAPTURE_FLAG_EVT = 3'h2;
	localparam logic [2:0] MODE_FREQ = 3'h3;
	localparam logic [2:0] MODE_PULSE = 3'h4;
	localparam logic [2:0] MODE_FREQ_PULSE = 3'h5;
	localparam logic [2:0] MODE_SINGLE = 3'h6;
	localparam logic [2:0] MODE_PWM8 = 3'h7;

	typedef enum logic [1:0] {FP_IDLE, FP_HIGH, FP_LOW, FP_DONE} ect_fp_e;
endpackage
